// >>> csc_pkg.sv
// Constants, types and helpers shared by the comparator status/control block
// Function
// - Enable bit 7 turns the whole comparator function on or off.
// - Bit 6 picks positive input: 0 external pin, 1 bandgap reference.
// - Event flag bit 5 sets on each compare event chosen by edge select.
// - Writing one to the flag clears it; writing zero leaves it.
// - With interrupt enable bit 4 set, request interrupt while flag set.
// - Bit 3 reads the present comparator output level, never a stored value.
// - Output readback resets to zero and reads zero while disabled.
// - Bit 2 set drives comparator output onto the output pin.
// - Edge select 00/10 falling, 01 rising, 11 either edge.
// - Comparator output high when positive input exceeds negative input.
// - All control, flag and readback bits live in one 8-bit register; here interrupt status and mask are two more registers.
// - Light stop: no compares, registers unchanged, resume afterwards.
// - Deep stop exit or reset returns every register bit to reset.
// - Output pin absent here, so the pin enable bit has no effect.
package csc_pkg;

	// Register byte offsets on the APB
	localparam logic [11:0] CSC_CTRL_OFFSET = 12'h000;
	localparam logic [11:0] CSC_STAT_OFFSET = 12'h004;
	localparam logic [11:0] CSC_MASK_OFFSET = 12'h008;

	// Field positions of the control register
	localparam int CSC_ENABLE_POS = 7;
	localparam int CSC_REFSEL_POS = 6;
	localparam int CSC_FLAG_POS = 5;
	localparam int CSC_IRQEN_POS = 4;
	localparam int CSC_LEVEL_POS = 3;
	localparam int CSC_PINEN_POS = 2;
	localparam int CSC_EDGE_POS = 0;

	// Reset values
	localparam logic [7:0] CSC_CTRL_RESET = 8'h00;
	localparam logic CSC_STAT_RESET = 1'b0;
	localparam logic CSC_MASK_RESET = 1'b0;

	// Synchroniser depth in clock cycles
	localparam int CSC_SYNC_STAGES = 2;

	// Compare event kinds
	typedef enum logic [1:0] {
		CSC_FALL_A = 2'b00,
		CSC_RISE = 2'b01,
		CSC_FALL_B = 2'b10,
		CSC_EITHER = 2'b11
	} csc_edge_t;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic enable;
		logic refSel;
		logic eventFlag;
		logic irqEnable;
		logic level;
		logic pinEnable;
		csc_edge_t edgeSel;
	} csc_ctrl_t;

	// Controls toward the analog comparator
	typedef struct packed {
		logic powerOn;
		logic refSel;
	} csc_analog_t;

	// True when the seen edge matches the selected event kind
	function automatic logic csc_event_hit(input csc_edge_t sel,
		input logic rise, input logic fall);
		logic hit;
		hit = 1'b0;
		unique case (sel)
			CSC_FALL_A: hit = fall;
			CSC_RISE: hit = rise;
			CSC_FALL_B: hit = fall;
			CSC_EITHER: hit = rise | fall;
		endcase
		return hit;
	endfunction

endpackage

// >>> csc_sync.sv
// Level synchroniser for the asynchronous comparator output
`timescale 1ns/100ps
module csc_sync #(
	parameter int STAGES = 2
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic dataIn,
	output logic dataOut
);

	logic [STAGES-1:0] chain;

	// Shift chain; only the next stage reads each stage
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			chain <= '0;
		end else begin
			chain <= {chain[STAGES-2:0], dataIn};
		end
	end

	assign dataOut = chain[STAGES-1];

endmodule

// >>> csc_control.sv
// Comparator status/control logic with APB slave and interrupt
`timescale 1ns/100ps
module csc_control import csc_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter bit PIN_PRESENT = 1'b0
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic compareRaw,
	input wire logic lightStop,
	input wire logic deepStopExit,
	output csc_analog_t analogCtrl,
	output logic comparePinOut,
	output logic irq
);

	csc_ctrl_t ctrl;
	csc_ctrl_t next_ctrl;
	csc_ctrl_t readCtrl;
	logic intStatus;
	logic intMask;
	logic prevLevel;
	logic armed;
	logic compareSync;
	logic [31:0] next_prdata;

	// Comparator output is synchronised before edge detect and readback
	csc_sync #(
		.STAGES(CSC_SYNC_STAGES)
	) u_sync (
		.clock(clock),
		.reset_n(reset_n),
		.dataIn(compareRaw),
		.dataOut(compareSync)
	);

	// Bus phase decode
	wire accessPhase = psel & penable;
	wire answerNow = accessPhase & ~pready;
	wire xferDone = accessPhase & pready;
	wire wrDone = xferDone & pwrite;
	wire rdDone = xferDone & ~pwrite;

	// Address decode
	wire [11:0] addr = 12'(paddr);
	wire hitCtrl = addr == CSC_CTRL_OFFSET;
	wire hitStat = addr == CSC_STAT_OFFSET;
	wire hitMask = addr == CSC_MASK_OFFSET;
	wire hitAny = hitCtrl | hitStat | hitMask;

	// Register write and clear strobes
	wire ctrlWrite = wrDone & hitCtrl;
	wire maskWrite = wrDone & hitMask;
	wire flagClear = ctrlWrite & pwdata[CSC_FLAG_POS];
	wire statClear = rdDone & hitStat;

	// Compares run only while enabled and out of light stop
	wire compareActive = ctrl.enable & ~lightStop;
	wire rise = compareSync & ~prevLevel;
	wire fall = ~compareSync & prevLevel;
	wire edgeHit = csc_event_hit(ctrl.edgeSel, rise, fall);
	wire compareEvent = compareActive & armed & edgeHit;

	// High level means positive input above negative input
	wire liveLevel = ctrl.enable & compareSync;

	// Next flag: a new event wins over a clear in the same cycle
	wire next_flag = compareEvent | (ctrl.eventFlag & ~flagClear);
	wire next_status = compareEvent | (intStatus & ~statClear);

	// Pin enable is kept only when the pin exists
	wire next_pinEn = PIN_PRESENT & pwdata[CSC_PINEN_POS];

	// Next control value from bus writes and events
	always_comb begin
		next_ctrl = ctrl;
		if (ctrlWrite) begin
			next_ctrl.enable = pwdata[CSC_ENABLE_POS];
			next_ctrl.refSel = pwdata[CSC_REFSEL_POS];
			next_ctrl.irqEnable = pwdata[CSC_IRQEN_POS];
			next_ctrl.pinEnable = next_pinEn;
			next_ctrl.edgeSel = csc_edge_t'(pwdata[CSC_EDGE_POS+:2]);
		end
		next_ctrl.level = 1'b0;
		next_ctrl.eventFlag = next_flag;
	end

	// Readable control view with the live level in bit 3
	always_comb begin
		readCtrl = ctrl;
		readCtrl.level = liveLevel;
	end

	// Read data selection; unmapped reads return zero
	assign next_prdata = hitCtrl ? {24'h00_0000, readCtrl} :
		hitStat ? {31'h0000_0000, intStatus} :
		hitMask ? {31'h0000_0000, intMask} : 32'h0000_0000;

	// Control, status and mask registers; deep stop exit restores reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl <= csc_ctrl_t'(CSC_CTRL_RESET);
			intStatus <= CSC_STAT_RESET;
			intMask <= CSC_MASK_RESET;
		end else if (deepStopExit) begin
			ctrl <= csc_ctrl_t'(CSC_CTRL_RESET);
			intStatus <= CSC_STAT_RESET;
			intMask <= CSC_MASK_RESET;
		end else begin
			ctrl <= next_ctrl;
			intStatus <= next_status;
			intMask <= maskWrite ? pwdata[0] : intMask;
		end
	end

	// Edge history; arming waits one cycle, while a high output reaches the edge detect as a rise three cycles after enabling
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prevLevel <= 1'b0;
			armed <= 1'b0;
		end else begin
			prevLevel <= compareSync;
			armed <= compareActive & ~deepStopExit;
		end
	end

	// APB answer: one wait cycle, then ready with data and error
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= answerNow;
			pslverr <= answerNow & ~hitAny;
			prdata <= answerNow ? next_prdata : prdata;
		end
	end

	// Registered outputs toward the analog side, pin and interrupt
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			analogCtrl <= '0;
			comparePinOut <= 1'b0;
			irq <= 1'b0;
		end else begin
			analogCtrl.powerOn <= compareActive;
			analogCtrl.refSel <= ctrl.refSel;
			comparePinOut <= PIN_PRESENT & ctrl.pinEnable & liveLevel;
			irq <= (ctrl.irqEnable & ctrl.eventFlag)
				| (intStatus & intMask);
		end
	end

	// Checks on the behaviour above
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	power_gate_a: assert property (
		!ctrl.enable |=> !analogCtrl.powerOn && !compareEvent)
		else $error("comparator powered while disabled");

	ref_route_a: assert property (
		ctrl.refSel != $past(ctrl.refSel) |-> ##1
		analogCtrl.refSel == $past(ctrl.refSel))
		else $error("reference select not routed");

	flag_sets_a: assert property (
		compareEvent && !deepStopExit |=> ctrl.eventFlag && intStatus)
		else $error("event did not set flag");

	flag_clear_a: assert property (
		flagClear && !compareEvent |=> !ctrl.eventFlag)
		else $error("flag not cleared by one");

	zero_keeps_a: assert property (
		ctrlWrite && !pwdata[CSC_FLAG_POS] && ctrl.eventFlag
		&& !deepStopExit |=> ctrl.eventFlag)
		else $error("writing zero cleared flag");

	irq_level_a: assert property (
		ctrl.irqEnable && ctrl.eventFlag |=> irq)
		else $error("interrupt missing while flag set");

	irq_quiet_a: assert property (
		!ctrl.irqEnable && !(intStatus && intMask) |=> !irq)
		else $error("interrupt without enable");

	live_read_a: assert property (
		answerNow && !pwrite && hitCtrl |=>
		prdata[CSC_LEVEL_POS] == $past(compareSync && ctrl.enable))
		else $error("level readback not live");

	level_zero_a: assert property (
		answerNow && hitCtrl && !ctrl.enable |=>
		!prdata[CSC_LEVEL_POS])
		else $error("level reads one while disabled");

	pin_off_a: assert property (
		!(PIN_PRESENT && ctrl.pinEnable) |=> !comparePinOut)
		else $error("pin driven without enable");

	rise_only_a: assert property (
		compareEvent && ctrl.edgeSel == CSC_RISE |-> rise)
		else $error("rising select fired on other edge");

	stop_hold_a: assert property (
		lightStop && !psel && !deepStopExit |=> ctrl == $past(ctrl)
		&& !compareEvent)
		else $error("light stop changed state");

	deep_reset_a: assert property (
		deepStopExit |=> ctrl == csc_ctrl_t'(CSC_CTRL_RESET)
		&& !intStatus && !intMask)
		else $error("deep stop exit left state");

	sync_depth_a: assert property (
		compareEvent |-> $past(compareRaw, 2) != $past(compareRaw, 3))
		else $error("event without synchronised edge");

	apb_wait_a: assert property (
		answerNow |=> pready ##1 !pready)
		else $error("ready not one cycle after access");

	ready_pulse_a: assert property (
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	ready_access_a: assert property (
		pready |-> psel && penable)
		else $error("ready outside an access phase");

	err_with_ready_a: assert property (
		pslverr |-> pready)
		else $error("error without ready");

	err_mapped_a: assert property (
		answerNow && hitAny |=> !pslverr)
		else $error("error on a mapped address");

	unmapped_zero_a: assert property (
		answerNow && !hitAny |=> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");

	read_hold_a: assert property (
		!answerNow |=> $stable(prdata))
		else $error("read data changed without a transfer");

	enable_write_a: assert property (
		ctrlWrite && !deepStopExit |=>
		ctrl.enable == $past(pwdata[CSC_ENABLE_POS]))
		else $error("enable bit not written");

	disabled_quiet_a: assert property (
		!ctrl.enable |-> !compareEvent)
		else $error("compare event while disabled");

	enable_settle_a: assert property (
		$rose(ctrl.enable) |-> !compareEvent)
		else $error("false event on enabling");

	power_follow_a: assert property (
		analogCtrl.powerOn == $past(ctrl.enable && !lightStop))
		else $error("analog power not following enable");

	refsel_write_a: assert property (
		ctrlWrite && !deepStopExit |=>
		ctrl.refSel == $past(pwdata[CSC_REFSEL_POS]))
		else $error("reference select not written");

	flag_source_a: assert property (
		$rose(ctrl.eventFlag) |-> $past(compareEvent))
		else $error("flag set without an event");

	status_source_a: assert property (
		$rose(intStatus) |-> $past(compareEvent))
		else $error("status set without an event");

	status_clear_a: assert property (
		statClear && !compareEvent |=> !intStatus)
		else $error("status not cleared by read");

	irqen_write_a: assert property (
		ctrlWrite && !deepStopExit |=>
		ctrl.irqEnable == $past(pwdata[CSC_IRQEN_POS]))
		else $error("interrupt enable not written");

	irq_mask_a: assert property (
		intStatus && intMask |=> irq)
		else $error("masked status gave no interrupt");

	irq_source_a: assert property (
		irq |-> $past(ctrl.irqEnable && ctrl.eventFlag
		|| intStatus && intMask))
		else $error("interrupt without a cause");

	level_unstored_a: assert property (
		!ctrl.level)
		else $error("level bit held in storage");

	level_gate_a: assert property (
		!ctrl.enable |-> !readCtrl.level)
		else $error("level visible while disabled");

	pin_bit_void_a: assert property (
		PIN_PRESENT || !ctrl.pinEnable)
		else $error("pin enable stored without a pin");

	fall_only_a: assert property (
		compareEvent && (ctrl.edgeSel == CSC_FALL_A
		|| ctrl.edgeSel == CSC_FALL_B) |-> fall)
		else $error("falling select fired on other edge");

	either_edge_a: assert property (
		compareActive && armed && ctrl.edgeSel == CSC_EITHER
		&& (rise || fall) |-> compareEvent)
		else $error("toggle select missed an edge");

	edge_write_a: assert property (
		ctrlWrite && !deepStopExit |=>
		ctrl.edgeSel == $past(pwdata[CSC_EDGE_POS+:2]))
		else $error("edge select not written");

	stop_power_a: assert property (
		lightStop |=> !analogCtrl.powerOn)
		else $error("comparator powered in light stop");

	deep_disarm_a: assert property (
		deepStopExit |=> !compareEvent)
		else $error("event right after deep stop exit");

	mask_write_a: assert property (
		maskWrite && !deepStopExit |=>
		intMask == $past(pwdata[0]))
		else $error("mask not written");

endmodule

// >>> csc_comparator_model.sv
// Behavioural analog comparator facing the control block
`timescale 1ns/100ps
module csc_comparator_model import csc_pkg::*; #(
	parameter int BANDGAP_MV = 1200
) (
	input wire csc_analog_t analogCtrl,
	input wire logic [11:0] posMv,
	input wire logic [11:0] negMv,
	output logic compareRaw
);
	// Powered down it drives low; refSel picks the positive source
	always_comb begin
		if (!analogCtrl.powerOn)
			compareRaw = 1'b0;
		else if (analogCtrl.refSel)
			compareRaw = BANDGAP_MV > int'(negMv);
		else
			compareRaw = posMv > negMv;
	end
endmodule

// >>> testbench.sv
// Self-checking bench for the comparator status/control block
`timescale 1ns/100ps
module testbench import csc_pkg::*;;
	logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000, posMv = 12'h1f4, negMv = 12'h3e8;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
	logic pready, pslverr, compareRaw, comparePinOut, irq, rerr, fl, rs;
	logic lightStop = 0, deepStopExit = 0;
	logic [1:0] md;
	csc_analog_t analogCtrl;
	int bad_count = 0, checks_done = 0, cycles = 0;

	csc_control u_csc_control (.clock(clock), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .compareRaw(compareRaw), .lightStop(lightStop),
		.deepStopExit(deepStopExit), .analogCtrl(analogCtrl),
		.comparePinOut(comparePinOut), .irq(irq));
	csc_comparator_model u_csc_comparator_model (.analogCtrl(analogCtrl),
		.posMv(posMv), .negMv(negMv), .compareRaw(compareRaw));

	// 250 MHz clock
	always #2 clock = ~clock;

	// Cuts a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			stop_test();
		end
	end

	// Counts and reports one comparison
	task automatic chk(input string what, input logic [31:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; waits for pready without assuming a latency
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Read and compare one register
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		xfer(0, a, 8'h00);
		chk($sformatf("reg %h", a), {24'h00_0000, e}, rdata);
		chk("pslverr", 0, rerr);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic stop_test();
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		wt(4);
		reset_n <= 1;
		rd(CSC_CTRL_OFFSET, 8'h00);
		rd(CSC_STAT_OFFSET, 8'h00);
		rd(CSC_MASK_OFFSET, 8'h00);
		xfer(0, 12'h00c, 8'h00);
		chk("pslverr", 1, rerr);
		// Every edge mode, with the pin enable written high
		for (int m = 0; m < 4; m++) begin
			md = m[1:0];
			fl = (md != 2'h1);
			rs = md[0];
			xfer(1, CSC_CTRL_OFFSET, {6'h21, md});
			posMv <= 12'h5dc;
			wt(6);
			chk("power", 1, analogCtrl.powerOn);
			chk("pin", 0, comparePinOut);
			rd(CSC_CTRL_OFFSET, {2'h2, rs, 3'h2, md});
			chk("irq", 0, irq);
			xfer(1, CSC_CTRL_OFFSET, {6'h28, md});
			posMv <= 12'h1f4;
			wt(6);
			xfer(1, CSC_CTRL_OFFSET, {6'h20, md});
			rd(CSC_CTRL_OFFSET, {2'h2, fl, 3'h0, md});
			xfer(1, CSC_CTRL_OFFSET, 8'h20);
		end
		// Edge while disabled sets nothing, level reads zero
		posMv <= 12'h5dc;
		wt(6);
		rd(CSC_CTRL_OFFSET, 8'h00);
		// Status left pending by the edge modes; reading clears it
		rd(CSC_STAT_OFFSET, 8'h01);
		// Interrupt through status and mask, then through the flag
		posMv <= 12'h1f4;
		xfer(1, CSC_MASK_OFFSET, 8'h01);
		xfer(1, CSC_CTRL_OFFSET, 8'h81);
		posMv <= 12'h5dc;
		wt(6);
		chk("irq", 1, irq);
		rd(CSC_STAT_OFFSET, 8'h01);
		wt(2);
		chk("irq", 0, irq);
		xfer(1, CSC_CTRL_OFFSET, 8'hb1);
		xfer(1, CSC_MASK_OFFSET, 8'h00);
		posMv <= 12'h1f4;
		wt(6);
		posMv <= 12'h5dc;
		wt(6);
		chk("irq", 1, irq);
		xfer(1, CSC_CTRL_OFFSET, 8'hb1);
		wt(2);
		chk("irq", 0, irq);
		// Bandgap as positive input
		xfer(1, CSC_CTRL_OFFSET, 8'h20);
		negMv <= 12'h5dc;
		xfer(1, CSC_CTRL_OFFSET, 8'hc0);
		wt(6);
		chk("refsel", 1, analogCtrl.refSel);
		rd(CSC_CTRL_OFFSET, 8'hc0);
		negMv <= 12'h3e8;
		wt(6);
		rd(CSC_CTRL_OFFSET, 8'hc8);
		// Light stop hides the falling edge and keeps the register
		xfer(1, CSC_CTRL_OFFSET, 8'hc2);
		lightStop <= 1;
		wt(8);
		chk("power", 0, analogCtrl.powerOn);
		lightStop <= 0;
		wt(8);
		rd(CSC_CTRL_OFFSET, 8'hca);
		// Deep stop exit clears everything, pending status too
		deepStopExit <= 1;
		wt(1);
		deepStopExit <= 0;
		rd(CSC_CTRL_OFFSET, 8'h00);
		rd(CSC_STAT_OFFSET, 8'h00);
		chk("power", 0, analogCtrl.powerOn);
		stop_test();
	end
endmodule
